// File: e1rx_status.sv
/*
  receive alarm status, national-bit report and identification registers.
  assumes framer event pulses and host strobes are on i_clock, one cycle each.
*/
`timescale 1ns/1ps
module e1rx_status
  import e1rx_pkg::*;
#(
  parameter int SECONDS = FAIL_SECONDS,
  parameter int SAME_COUNT = SAME_NIBBLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // host port
  input wire logic [7:0] i_page,
  input wire logic [4:0] i_addr,
  input wire logic i_rd_strobe,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  // bit stream
  input wire logic i_bit_en,
  input wire logic i_bit,
  // submultiframe check
  input wire logic i_smf_end,
  input wire logic i_smf_second,
  input wire logic i_smf_check_fail,
  // per second
  input wire logic i_second,
  input wire logic [9:0] i_ebit_count,
  input wire logic i_align_lost,
  // frame events
  input wire logic i_frame_end,
  input wire logic i_slot16_ones,
  input wire logic i_ais_crit_a,
  input wire logic i_ais_crit_b,
  input wire logic i_nfas_frame,
  input wire logic i_a_bit,
  input wire logic i_mf_end,
  input wire logic i_rai_crc_cond,
  // national bits
  input wire logic i_nibble_valid,
  input wire logic [3:0] i_national_bit_six,
  input wire logic i_national_bit_five,
  // status out
  output logic o_alarm_criteria_select,
  output logic [7:0] o_alarm_status
);
  initial begin
    if (SECONDS < 1 || SECONDS > 7 || SAME_COUNT < 2 || SAME_COUNT > 15) begin
      $error("e1rx_status: bad counts");
    end
  end

  function automatic logic hit(input logic [7:0] page, input logic [4:0] addr,
                               input logic [7:0] pg, input logic [4:0] ofs);
    hit = (page == pg) && (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic nopulse;
  e1rx_nopulse u_nopulse (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_bit_en(i_bit_en),
    .i_bit(i_bit),
    .o_nopulse(nopulse)
  );

  ////////////////////////////////////////////////////////////////////////
  logic smf1_r, smf1_nxt, smf2_r, smf2_nxt;
  logic slot16_r, slot16_nxt, ais_r, ais_nxt;
  logic rai_r, rai_nxt, raicrc_r, raicrc_nxt;
  logic alarm_criteria_select_r, alarm_criteria_select_nxt;
  logic [2:0] sec_cnt_r, sec_cnt_nxt;
  logic rai_seen_r, rai_seen_nxt, sync_seen_r, sync_seen_nxt;
  logic remote_generator_failure;

  always_comb begin
    smf1_nxt = smf1_r;
    smf2_nxt = smf2_r;
    slot16_nxt = slot16_r;
    ais_nxt = ais_r;
    rai_nxt = rai_r;
    raicrc_nxt = raicrc_r;
    alarm_criteria_select_nxt = alarm_criteria_select_r;
    sec_cnt_nxt = sec_cnt_r;
    rai_seen_nxt = rai_seen_r | rai_r;
    sync_seen_nxt = sync_seen_r | i_align_lost;
    if (i_smf_end && !i_smf_second) begin
      smf1_nxt = i_smf_check_fail;
    end
    if (i_smf_end && i_smf_second) begin
      smf2_nxt = i_smf_check_fail;
    end
    if (i_frame_end) begin
      slot16_nxt = i_slot16_ones;
    end
    if (i_frame_end) begin
      ais_nxt = alarm_criteria_select_r ? i_ais_crit_b : i_ais_crit_a;
    end
    if (i_nfas_frame) begin
      rai_nxt = i_a_bit;
    end
    if (i_mf_end) begin
      raicrc_nxt = i_rai_crc_cond;
    end
    if (i_wr_strobe && hit(i_page, i_addr, PAGE_CONTROL, OFS_CRITERIA_CTRL)) begin
      alarm_criteria_select_nxt = i_wdata[CRITERIA_BIT];
    end
    if (i_second) begin
      if (i_ebit_count > EBIT_LIMIT && !rai_seen_nxt && !sync_seen_nxt) begin
        sec_cnt_nxt = (sec_cnt_r == 3'(SECONDS)) ? sec_cnt_r : sec_cnt_r + 3'h1;
      end else begin
        sec_cnt_nxt = 3'h0;
      end
      rai_seen_nxt = rai_r;
      sync_seen_nxt = i_align_lost;
    end
  end

  // flag drops at once on alarm or lost alignment
  assign remote_generator_failure = (sec_cnt_r == 3'(SECONDS)) && !rai_seen_r && !rai_r && !sync_seen_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      smf1_r <= 1'b0;
      smf2_r <= 1'b0;
      slot16_r <= 1'b0;
      ais_r <= 1'b0;
      rai_r <= 1'b0;
      raicrc_r <= 1'b0;
      alarm_criteria_select_r <= 1'b0;
      sec_cnt_r <= 3'h0;
      rai_seen_r <= 1'b0;
      sync_seen_r <= 1'b0;
    end else begin
      smf1_r <= smf1_nxt;
      smf2_r <= smf2_nxt;
      slot16_r <= slot16_nxt;
      ais_r <= ais_nxt;
      rai_r <= rai_nxt;
      raicrc_r <= raicrc_nxt;
      alarm_criteria_select_r <= alarm_criteria_select_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      rai_seen_r <= rai_seen_nxt;
      sync_seen_r <= sync_seen_nxt;
    end
  end

  logic [7:0] alarm_word;
  always_comb begin
    alarm_word = RESET_STATUS;
    alarm_word[BIT_SMF1] = smf1_r;
    alarm_word[BIT_SMF2] = smf2_r;
    alarm_word[BIT_REMOTE_GENERATOR_FAILURE] = remote_generator_failure;
    alarm_word[BIT_NOPULSE] = nopulse;
    alarm_word[BIT_SLOT16] = slot16_r;
    alarm_word[BIT_ALL_ONES] = ais_r;
    alarm_word[BIT_RAI] = rai_r;
    alarm_word[BIT_RAI_CRC] = raicrc_r;
  end

  ////////////////////////////////////////////////////////////////////////
  logic [3:0] prev_nib_r, prev_nib_nxt;
  logic prev_ok_r, prev_ok_nxt;
  logic [3:0] same_r, same_nxt;
  logic [3:0] nib_latch_r, nib_latch_nxt;
  logic sa5_latch_r, sa5_latch_nxt;
  logic eight_r, eight_nxt, change_r, change_nxt;
  logic rd_report;

  assign rd_report = i_rd_strobe && hit(i_page, i_addr, PAGE_STATUS, OFS_NAT_REPORT);

  always_comb begin
    prev_nib_nxt = prev_nib_r;
    prev_ok_nxt = prev_ok_r;
    same_nxt = same_r;
    nib_latch_nxt = nib_latch_r;
    sa5_latch_nxt = sa5_latch_r;
    eight_nxt = eight_r;
    change_nxt = change_r;
    // read clears; a set in the same cycle wins below
    if (rd_report) begin
      nib_latch_nxt = 4'h0;
      sa5_latch_nxt = 1'b0;
      eight_nxt = 1'b0;
      change_nxt = 1'b0;
    end
    if (i_nibble_valid) begin
      prev_nib_nxt = i_national_bit_six;
      prev_ok_nxt = 1'b1;
      if (prev_ok_r && i_national_bit_six != prev_nib_r) begin
        change_nxt = 1'b1;
        same_nxt = 4'h1;
      end else if (same_r != 4'(SAME_COUNT)) begin
        same_nxt = same_r + 4'h1;
        if (same_r == 4'(SAME_COUNT - 1)) begin
          eight_nxt = 1'b1;
          nib_latch_nxt = i_national_bit_six;
          sa5_latch_nxt = i_national_bit_five;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prev_nib_r <= 4'h0;
      prev_ok_r <= 1'b0;
      same_r <= 4'h0;
      nib_latch_r <= 4'h0;
      sa5_latch_r <= 1'b0;
      eight_r <= 1'b0;
      change_r <= 1'b0;
    end else begin
      prev_nib_r <= prev_nib_nxt;
      prev_ok_r <= prev_ok_nxt;
      same_r <= same_nxt;
      nib_latch_r <= nib_latch_nxt;
      sa5_latch_r <= sa5_latch_nxt;
      eight_r <= eight_nxt;
      change_r <= change_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r;

  // alarm word read only samples, no state is touched
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(i_page, i_addr, PAGE_STATUS, OFS_ALARM_STATUS)) begin
      rdata_nxt = alarm_word;
    end else if (hit(i_page, i_addr, PAGE_STATUS, OFS_NAT_REPORT)) begin
      rdata_nxt = {sa5_latch_r, nib_latch_r, 1'b0, eight_r, change_r};
    end else if (hit(i_page, i_addr, PAGE_STATUS, OFS_DEVICE_ID)) begin
      rdata_nxt = PART_CODE_VALUE;
    end else if (hit(i_page, i_addr, PAGE_CONTROL, OFS_CRITERIA_CTRL)) begin
      rdata_nxt[CRITERIA_BIT] = alarm_criteria_select_r;
    end
    if (!i_rd_strobe) begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= i_rd_strobe;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rd_valid = rvalid_r;
  assign o_alarm_status = alarm_word;
  assign o_alarm_criteria_select = alarm_criteria_select_r;

  ////////////////////////////////////////////////////////////////////////
  a_smf1_update: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_smf_end && !i_smf_second) |=> (smf1_r == $past(i_smf_check_fail)))
    else $error("submultiframe 1 status wrong");
  a_smf2_update: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_smf_end && i_smf_second) |=> (smf2_r == $past(i_smf_check_fail)))
    else $error("submultiframe 2 status wrong");
  a_remote_generator_failure_needs_five: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    remote_generator_failure |-> (sec_cnt_r == 3'(SECONDS) && !rai_r && !$past(i_align_lost)))
    else $error("generator failure without five seconds");
  a_slot16_frame: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!i_frame_end ##1 1'b1) |-> $stable(slot16_r))
    else $error("slot 16 bit moved between frames");
  a_criteria_pick: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_frame_end |=> (ais_r == ($past(alarm_criteria_select_r) ? $past(i_ais_crit_b) : $past(i_ais_crit_a))))
    else $error("all-ones alarm ignores criteria select");
  a_rai_follow: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_nfas_frame |=> (o_alarm_status[BIT_RAI] == $past(i_a_bit)))
    else $error("remote alarm bit not updated");
  a_raicrc_mf: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_mf_end |=> (raicrc_r == $past(i_rai_crc_cond)))
    else $error("combined alarm not updated");
  a_eight_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_nibble_valid && same_r == 4'(SAME_COUNT - 1) && prev_ok_r && i_national_bit_six == prev_nib_r)
    |=> (eight_r && nib_latch_r == $past(i_national_bit_six)))
    else $error("eighth nibble not latched");
  a_change_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_nibble_valid && prev_ok_r && i_national_bit_six != prev_nib_r) |=> change_r)
    else $error("nibble change missed");
  a_read_clears: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (rd_report && !i_nibble_valid) |=> (!eight_r && !change_r && nib_latch_r == 4'h0 && !sa5_latch_r))
    else $error("report read did not clear");
  a_id_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_rd_strobe && hit(i_page, i_addr, PAGE_STATUS, OFS_DEVICE_ID)) |=> (o_rd_valid && o_rdata == PART_CODE_VALUE))
    else $error("identification code wrong");
  a_status_read_pure: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_rd_strobe && !i_smf_end && !i_frame_end && !i_nfas_frame && !i_mf_end && !i_second)
    |=> ($past(smf1_r) == smf1_r && $past(rai_r) == rai_r && $past(raicrc_r) == raicrc_r))
    else $error("status read changed state");
  c_remote_generator_failure: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(remote_generator_failure));
  c_eight: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(eight_r));
  c_clear: cover property (@(posedge i_clock) disable iff (!i_rst_n) eight_r ##1 rd_report ##1 !eight_r);
endmodule

// File: e1rx_pkg.sv
/*
  constants for the receive alarm, national-bit and identification registers.
  assumes one 250 MHz clock shared with the receive framer and the host port.
*/
// Function
// - end of submultiframe 1 sets bit 7 on check failure, clears otherwise
// - end of submultiframe 2 sets bit 6 on check failure, clears otherwise
// - bit 5 needs five seconds over 989 errors, no remote alarm, alignment held
// - 127 consecutive zero bit periods enter no-pulse alarm, shown in bit 4
// - leave no-pulse alarm after 127-position window starting with pulse, density 12.5%
// - bit 3 shows all ones in slot 16, re-evaluated every frame
// - bit 2 shows all-ones alarm, criteria picked by select bit at page 1 10H
// - bit 1 follows received A bit, updated each non-alignment frame
// - bit 0 shows remote alarm with continuous check errors, updated per multiframe
// - eighth identical nibble sets bit 1, latches bit five and nibble
// - bit 0 of report word set on any change between successive nibbles
// - reading report word clears latched bits and both flags; bit 2 unused
// - identification word at page 3 1FH returns fixed 8-bit code
package e1rx_pkg;
  localparam logic [7:0] PAGE_STATUS = 8'h03;
  localparam logic [7:0] PAGE_CONTROL = 8'h01;
  localparam logic [4:0] OFS_ALARM_STATUS = 5'h19;
  localparam logic [4:0] OFS_NAT_REPORT = 5'h1a;
  localparam logic [4:0] OFS_DEVICE_ID = 5'h1f;
  localparam logic [4:0] OFS_CRITERIA_CTRL = 5'h10;
  localparam int CRITERIA_BIT = 0;
  // arbitrary neutral value
  localparam logic [7:0] PART_CODE_VALUE = 8'h5c;
  localparam int BIT_SMF1 = 7;
  localparam int BIT_SMF2 = 6;
  localparam int BIT_REMOTE_GENERATOR_FAILURE = 5;
  localparam int BIT_NOPULSE = 4;
  localparam int BIT_SLOT16 = 3;
  localparam int BIT_ALL_ONES = 2;
  localparam int BIT_RAI = 1;
  localparam int BIT_RAI_CRC = 0;
  localparam int NAT_SA5_BIT = 7;
  localparam int NAT_NIB_LSB = 3;
  localparam int NAT_EIGHT_BIT = 1;
  localparam int NAT_CHANGE_BIT = 0;
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam int NOPULSE_ZERO_RUN = 127;
  localparam int NOPULSE_WINDOW = 127;
  // 12.5% of 127 positions, rounded up to whole pulses
  localparam int NOPULSE_MIN_ONES = 16;
  localparam logic [9:0] EBIT_LIMIT = 10'h3dd;
  localparam int FAIL_SECONDS = 5;
  localparam int SAME_NIBBLES = 8;
endpackage

// File: e1rx_nopulse.sv
/*
  no-pulse (loss of signal) detector on the recovered bit stream.
  assumes i_bit_en marks one received bit period, on the same clock.
*/
`timescale 1ns/1ps
module e1rx_nopulse
  import e1rx_pkg::*;
#(
  parameter int RUN_LEN = NOPULSE_ZERO_RUN,
  parameter int WIN_LEN = NOPULSE_WINDOW,
  parameter int MIN_ONES = NOPULSE_MIN_ONES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // bit stream
  input wire logic i_bit_en,
  input wire logic i_bit,
  // state
  output logic o_nopulse
);
  initial begin
    if (RUN_LEN < 2 || RUN_LEN > 255 || WIN_LEN < 2 || WIN_LEN > 255 || MIN_ONES > WIN_LEN) begin
      $error("e1rx_nopulse: bad lengths");
    end
  end

  logic los_r, los_nxt;
  logic win_r, win_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] ones_r, ones_nxt;

  always_comb begin
    los_nxt = los_r;
    win_nxt = win_r;
    cnt_nxt = cnt_r;
    ones_nxt = ones_r;
    if (i_bit_en) begin
      if (!los_r) begin
        if (i_bit) begin
          cnt_nxt = 8'h00;
        end else if (cnt_r == 8'(RUN_LEN - 1)) begin
          los_nxt = 1'b1;
          cnt_nxt = 8'h00;
          win_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end else if (!win_r) begin
        if (i_bit) begin
          win_nxt = 1'b1;
          cnt_nxt = 8'h01;
          ones_nxt = 8'h01;
        end
      end else begin
        cnt_nxt = cnt_r + 8'h01;
        ones_nxt = ones_r + {7'h00, i_bit};
        if (cnt_r == 8'(WIN_LEN - 1)) begin
          win_nxt = 1'b0;
          cnt_nxt = 8'h00;
          los_nxt = (ones_nxt < 8'(MIN_ONES));
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      los_r <= 1'b0;
      win_r <= 1'b0;
      cnt_r <= 8'h00;
      ones_r <= 8'h00;
    end else begin
      los_r <= los_nxt;
      win_r <= win_nxt;
      cnt_r <= cnt_nxt;
      ones_r <= ones_nxt;
    end
  end

  assign o_nopulse = los_r;

  a_run_enters_los: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!los_r && i_bit_en && !i_bit && cnt_r == 8'(RUN_LEN - 1)) |=> los_r)
    else $error("zero run did not raise no-pulse");
  a_pulse_blocks_los: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!los_r && i_bit_en && i_bit) |=> !los_r)
    else $error("no-pulse raised on a pulse");
  a_exit_needs_window: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (los_r && !(win_r && i_bit_en && cnt_r == 8'(WIN_LEN - 1))) |=> los_r)
    else $error("no-pulse left outside window end");
  c_los_exit: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(los_r));
endmodule

// File: e1rx_frm_model.sv
/*
  framer-side model: pulses receive events and bit periods into the status block.
  assumes the bench calls its tasks from one process; drives on falling edges.
*/
`timescale 1ns/1ps
module e1rx_frm_model (
  // clock
  input wire logic i_clock,
  // bit stream
  output logic o_bit_en,
  output logic o_bit,
  // framer events and their data
  output logic o_smf_end,
  output logic o_smf_second,
  output logic o_smf_fail,
  output logic o_second,
  output logic [9:0] o_ebits,
  output logic o_frame_end,
  output logic o_s16,
  output logic o_ais_a,
  output logic o_ais_b,
  output logic o_nfas,
  output logic o_a_bit,
  output logic o_mf_end,
  output logic o_rai_crc,
  output logic o_nib_valid,
  output logic [3:0] o_sa6,
  output logic o_sa5
);
  initial begin
    {o_bit_en, o_bit, o_smf_end, o_smf_second, o_smf_fail, o_second, o_ebits, o_frame_end, o_s16} = '0;
    {o_ais_a, o_ais_b, o_nfas, o_a_bit, o_mf_end, o_rai_crc, o_nib_valid, o_sa6, o_sa5} = '0;
  end
  ////////////////////////////////////////////////////////////
  // released data shows the inverse, so a stale value never passes
  task automatic bits(input int n, input logic v);
    repeat (n) begin
      @(negedge i_clock);
      o_bit_en = 1'b1;
      o_bit = v;
    end
    @(negedge i_clock);
    o_bit_en = 1'b0;
    o_bit = ~v;
    @(negedge i_clock);
  endtask
  task automatic smf(input logic s2, input logic f);
    @(negedge i_clock);
    {o_smf_end, o_smf_second, o_smf_fail} = {1'b1, s2, f};
    @(negedge i_clock);
    {o_smf_end, o_smf_second, o_smf_fail} = {1'b0, ~s2, ~f};
  endtask
  task automatic sec(input logic [9:0] c);
    @(negedge i_clock);
    {o_second, o_ebits} = {1'b1, c};
    @(negedge i_clock);
    {o_second, o_ebits} = {1'b0, ~c};
  endtask
  task automatic frame(input logic s, input logic a, input logic b);
    @(negedge i_clock);
    {o_frame_end, o_s16, o_ais_a, o_ais_b} = {1'b1, s, a, b};
    @(negedge i_clock);
    {o_frame_end, o_s16, o_ais_a, o_ais_b} = {1'b0, ~s, ~a, ~b};
  endtask
  task automatic nfas(input logic a);
    @(negedge i_clock);
    {o_nfas, o_a_bit} = {1'b1, a};
    @(negedge i_clock);
    {o_nfas, o_a_bit} = {1'b0, ~a};
  endtask
  task automatic mf(input logic c);
    @(negedge i_clock);
    {o_mf_end, o_rai_crc} = {1'b1, c};
    @(negedge i_clock);
    {o_mf_end, o_rai_crc} = {1'b0, ~c};
  endtask
  // several framer events in one cycle; mask is {nib, mf, nfas, frame, second, smf}
  task automatic multi(input logic [5:0] m, input logic d);
    @(negedge i_clock);
    {o_nib_valid, o_mf_end, o_nfas, o_frame_end, o_second, o_smf_end} = m;
    {o_smf_second, o_smf_fail, o_s16, o_ais_a, o_ais_b, o_a_bit, o_rai_crc, o_sa5} = {8{d}};
    {o_ebits, o_sa6} = {14{d}};
    @(negedge i_clock);
    {o_nib_valid, o_mf_end, o_nfas, o_frame_end, o_second, o_smf_end} = 6'h00;
    {o_smf_second, o_smf_fail, o_s16, o_ais_a, o_ais_b, o_a_bit, o_rai_crc, o_sa5} = {8{~d}};
    {o_ebits, o_sa6} = {14{~d}};
  endtask
  task automatic nib(input logic [3:0] n, input logic s5);
    @(negedge i_clock);
    {o_nib_valid, o_sa6, o_sa5} = {1'b1, n, s5};
    @(negedge i_clock);
    {o_nib_valid, o_sa6, o_sa5} = {1'b0, ~n, ~s5};
  endtask
endmodule

// File: tb_top.sv
/*
  self-checking bench for the receive status registers.
  assumes the framer model partner; SECONDS is shortened to 2 to keep the run brief.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t mismatch", $time); end end
module tb_top;
  import e1rx_pkg::*;
  logic clock, rst_n, rd, wr, align_lost, sel, rd_valid;
  logic [7:0] page, wdata, rdata, alarm;
  logic [4:0] addr;
  logic bit_en, bit_v, smf_end, smf_2, smf_fail, sec, frame_end, s16, ais_a, ais_b;
  logic nfas, a_bit, mf_end, rai_crc, nib_v, sa5;
  logic [9:0] ebits;
  logic [3:0] sa6;
  int num_errors, n_compared, cycles;
  e1rx_status #(.SECONDS(2), .SAME_COUNT(8)) i_dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_page(page), .i_addr(addr), .i_rd_strobe(rd),
    .i_wr_strobe(wr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .i_bit_en(bit_en), .i_bit(bit_v), .i_smf_end(smf_end), .i_smf_second(smf_2),
    .i_smf_check_fail(smf_fail), .i_second(sec), .i_ebit_count(ebits), .i_align_lost(align_lost),
    .i_frame_end(frame_end), .i_slot16_ones(s16), .i_ais_crit_a(ais_a), .i_ais_crit_b(ais_b),
    .i_nfas_frame(nfas), .i_a_bit(a_bit), .i_mf_end(mf_end), .i_rai_crc_cond(rai_crc),
    .i_nibble_valid(nib_v), .i_national_bit_six(sa6), .i_national_bit_five(sa5),
    .o_alarm_criteria_select(sel), .o_alarm_status(alarm));
  e1rx_frm_model i_frm (
    .i_clock(clock), .o_bit_en(bit_en), .o_bit(bit_v), .o_smf_end(smf_end), .o_smf_second(smf_2),
    .o_smf_fail(smf_fail), .o_second(sec), .o_ebits(ebits), .o_frame_end(frame_end), .o_s16(s16),
    .o_ais_a(ais_a), .o_ais_b(ais_b), .o_nfas(nfas), .o_a_bit(a_bit), .o_mf_end(mf_end),
    .o_rai_crc(rai_crc), .o_nib_valid(nib_v), .o_sa6(sa6), .o_sa5(sa5));
  ////////////////////////////////////////////////////////////
  initial clock = 1'b0;
  always #2 clock = ~clock;
  // cut a hang short well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] pg, input logic [4:0] ofs, input logic [7:0] exp);
    @(negedge clock);
    {page, addr, rd} = {pg, ofs, 1'b1};
    @(negedge clock);
    rd = 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rdata, exp)
  endtask
  task automatic wr_reg(input logic [7:0] pg, input logic [4:0] ofs, input logic [7:0] d);
    @(negedge clock);
    {page, addr, wdata, wr} = {pg, ofs, d, 1'b1};
    @(negedge clock);
    wr = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_n, rd, wr, align_lost, page, addr, wdata} = '0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    `CHK(alarm, RESET_STATUS)
    chk_rd(PAGE_STATUS, OFS_NAT_REPORT, 8'h00);
    chk_rd(PAGE_STATUS, OFS_DEVICE_ID, PART_CODE_VALUE);
    chk_rd(PAGE_STATUS, 5'h1b, 8'h00);
    chk_rd(PAGE_CONTROL, OFS_CRITERIA_CTRL, 8'h00);
    i_frm.smf(1'b0, 1'b1);
    `CHK(alarm, 8'h80)
    i_frm.smf(1'b1, 1'b1);
    `CHK(alarm, 8'hc0)
    i_frm.smf(1'b0, 1'b0);
    `CHK(alarm, 8'h40)
    // a write to a read-only place must not disturb it
    wr_reg(PAGE_STATUS, OFS_ALARM_STATUS, 8'hff);
    chk_rd(PAGE_STATUS, OFS_ALARM_STATUS, 8'h40);
    chk_rd(PAGE_STATUS, OFS_ALARM_STATUS, 8'h40);
    i_frm.smf(1'b1, 1'b0);
    `CHK(alarm, 8'h00)
    i_frm.frame(1'b1, 1'b1, 1'b0);
    `CHK(alarm, 8'h0c)
    wr_reg(8'h02, OFS_CRITERIA_CTRL, 8'h01);
    `CHK(sel, 1'b0)
    wr_reg(PAGE_CONTROL, OFS_CRITERIA_CTRL, 8'h01);
    chk_rd(PAGE_CONTROL, OFS_CRITERIA_CTRL, 8'h01);
    i_frm.frame(1'b0, 1'b1, 1'b0);
    `CHK(alarm, 8'h00)
    i_frm.frame(1'b0, 1'b0, 1'b1);
    `CHK(alarm, 8'h04)
    i_frm.nfas(1'b1);
    i_frm.mf(1'b1);
    `CHK(alarm, 8'h07)
    i_frm.nfas(1'b0);
    `CHK(alarm, 8'h05)
    i_frm.mf(1'b0);
    `CHK(alarm, 8'h04)
    // the first second saw the remote alarm raised, so it does not qualify
    repeat (2) i_frm.sec(10'h3de);
    @(negedge clock);
    `CHK(alarm[BIT_REMOTE_GENERATOR_FAILURE], 1'b0)
    i_frm.sec(10'h3de);
    @(negedge clock);
    `CHK(alarm[BIT_REMOTE_GENERATOR_FAILURE], 1'b1)
    align_lost = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(alarm[BIT_REMOTE_GENERATOR_FAILURE], 1'b0)
    align_lost = 1'b0;
    repeat (3) i_frm.sec(10'h3de);
    @(negedge clock);
    `CHK(alarm[BIT_REMOTE_GENERATOR_FAILURE], 1'b1)
    // 989 is the boundary: not above the limit
    i_frm.sec(10'h3dd);
    @(negedge clock);
    `CHK(alarm[BIT_REMOTE_GENERATOR_FAILURE], 1'b0)
    i_frm.bits(126, 1'b0);
    `CHK(alarm[BIT_NOPULSE], 1'b0)
    i_frm.bits(1, 1'b0);
    `CHK(alarm[BIT_NOPULSE], 1'b1)
    i_frm.bits(15, 1'b1);
    i_frm.bits(112, 1'b0);
    `CHK(alarm[BIT_NOPULSE], 1'b1)
    i_frm.bits(16, 1'b1);
    i_frm.bits(110, 1'b0);
    `CHK(alarm[BIT_NOPULSE], 1'b1)
    i_frm.bits(1, 1'b0);
    `CHK(alarm[BIT_NOPULSE], 1'b0)
    repeat (7) i_frm.nib(4'h6, 1'b1);
    chk_rd(PAGE_STATUS, OFS_NAT_REPORT, 8'h00);
    i_frm.nib(4'h6, 1'b1);
    chk_rd(PAGE_STATUS, OFS_NAT_REPORT, 8'hb2);
    chk_rd(PAGE_STATUS, OFS_NAT_REPORT, 8'h00);
    i_frm.nib(4'h3, 1'b0);
    chk_rd(PAGE_STATUS, OFS_NAT_REPORT, 8'h01);
    repeat (7) i_frm.nib(4'h3, 1'b0);
    chk_rd(PAGE_STATUS, OFS_NAT_REPORT, 8'h1a);
    // all framer events in one cycle; the second qualifies but is only the first
    i_frm.multi(6'h3f, 1'b1);
    `CHK(alarm, 8'h4f)
    chk_rd(PAGE_STATUS, OFS_NAT_REPORT, 8'h01);
    // second reset in mid-run
    i_frm.smf(1'b0, 1'b1);
    rst_n = 1'b0;
    @(negedge clock);
    rst_n = 1'b1;
    `CHK(alarm, RESET_STATUS)
    `CHK(sel, 1'b0)
    `CHK(rdata, 8'h00)
    tally_and_finish();
  end
endmodule
